// >>> design/twb_defs.svh
/*
 * Register indices, field positions, reset values and bus timing counts of the
 * two-wire bus master engine.
 * Assumes a 125 MHz block clock and a word-aligned Avalon-MM register window.
 */
`ifndef TWB_DEFS_SVH
`define TWB_DEFS_SVH

// Register indices; the byte address of each register is four times its index.
`define TWB_IDX_DATA    3'h0
`define TWB_IDX_STATUS  3'h1
`define TWB_IDX_CTLSTAT 3'h2
`define TWB_IDX_CTL1    3'h3
`define TWB_IDX_OWNADDR 3'h4
`define TWB_IDX_DIV     3'h5

// Status register fields.
`define TWB_ST_BEF      6
`define TWB_ST_BER      5
`define TWB_ST_NACK     4
`define TWB_ST_SST      3
`define TWB_ST_MASTER   1
`define TWB_ST_XMIT     0

// Control status register fields.
`define TWB_CS_OCC      1

// Control one register fields.
`define TWB_C1_START    0
`define TWB_C1_STOP     1
`define TWB_C1_IRQEN    2
`define TWB_C1_REFUSE   3
`define TWB_C1_SSE      7

// Own address register fields.
`define TWB_OA_MEN      7

// Reset values.
`define TWB_OWNADDR_RST 8'h00

// Bus timing: one clock-line phase lasts the divider value plus one cycle.
`define TWB_CLK_NS      8
`define TWB_HALF_NS     5000
`define TWB_HALF_CYC    ((`TWB_HALF_NS) / (`TWB_CLK_NS))
`define TWB_DIV_RST     16'((`TWB_HALF_CYC) - 1)

`endif

// >>> design/twb_pkg.sv
/*
 * Types of the two-wire bus master engine: engine states, line drive bundle
 * and the full state record of the engine.
 * Assumes twb_defs.svh supplies all numeric constants except the state codes, which are set here.
 */
package twb_pkg;

    typedef enum logic [9:0] {
        S_IDLE   = 10'h001,
        S_SETUP  = 10'h002,
        S_HOLD   = 10'h004,
        S_STALL  = 10'h008,
        S_LOW    = 10'h010,
        S_HIGH   = 10'h020,
        S_STOPA  = 10'h040,
        S_STOPB  = 10'h080,
        S_STOPC  = 10'h100,
        S_RSREL  = 10'h200
    } twb_state_e;

    typedef struct packed {
        logic scl_out;
        logic scl_oe;
        logic sda_out;
        logic sda_oe;
    } twb_line_drv_s;

    typedef struct packed {
        twb_state_e st;
        logic [15:0] cnt;
        logic [15:0] div;
        logic [3:0]  bitn;
        logic [7:0]  sh;
        logic [7:0]  data;
        logic [7:0]  own_addr;
        logic [7:0]  rdata;
        logic        ack;
        logic        scl_m;
        logic        scl_s;
        logic        scl_d;
        logic        sda_m;
        logic        sda_s;
        logic        sda_d;
        logic        smp;
        logic        scl_drv;
        logic        sda_drv;
        logic        bef;
        logic        bus_error_flag;
        logic        nack;
        logic        sst;
        logic        master;
        logic        xmit;
        logic        rx;
        logic        addr_ph;
        logic        pend;
        logic        occ;
        logic        start_req;
        logic        stop_req;
        logic        irq_en;
        logic        refuse;
        logic        sse;
        logic        irq;
    } twb_regs_s;

endpackage

// >>> design/twb_master.sv
/*
 * Two-wire bus master engine with an Avalon-MM register slave.
 * Assumes open-drain clock and data lines with pull-ups outside, and pin inputs
 * that are asynchronous to clk.
 */
// The register offsets and the Avalon-MM slave port were decided locally.
// Function
// - Master clocks a ninth acknowledge pulse; receiver acknowledges unless unable.
// - On master read, last byte gets negative acknowledge; data line left released.
// - Seven address bits follow Start; eighth bit: 1 read, 0 write.
// - First byte 00h is a general call; second byte gives its meaning.
// - Data rising while clock high is a Stop and ends the transaction.
// - Master aborts when sampled data differs from driven, except while receiving or on the acknowledge bit.
// - Clock period follows slowest party; high phase ends with shortest high.
// - Arbitration lost in address: drop bus, become slave, keep watching data.
// - Start request waits for free bus, issues Start, then holds clock low.
// - Clock pulled low during Start sets bus error; else master and buffer-empty.
// - Interrupt enable raises request on bus error, empty, refused or stall flag.
// - Writing address byte as master launches it; acknowledge copied to refused.
// - Conflict during master transfer aborts, sets bus error, clears master.
// - Stall enable with clean address sets start-stall flag, holds clock low.
// - Clean address: transmit sets buffer-empty; receive without stall starts reading.
// - Byte written while empty is sent; refusal sets refused, empty stays clear.
// - Software sets refuse-next before last byte; device sends negative acknowledge.
// - Stop request while master sends Stop at once and clears itself.
// - Master holds clock low after acknowledge while refused, empty or start-stall.
// - Bytes move most significant bit first in both directions.
// - Data falling while clock high is generated and recognized as Start.
`timescale 1ns/10ps
`include "twb_defs.svh"

module twb_master (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic [4:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    input  wire logic                   scl_in,
    input  wire logic                   sda_in,
    output twb_pkg::twb_line_drv_s      line_drv,
    output logic                        irq
);
    import twb_pkg::*;

    twb_regs_s s_r;
    twb_regs_s s_nxt;

    logic       acc;
    logic [2:0] idx;
    logic       tick;
    logic       start_ev;
    logic       stop_ev;
    logic       stall;
    logic       rx_now;
    logic       hi_end;
    logic       go_tx;
    logic       go_rx;
    logic       abort;

    assign acc             = avs_read | avs_write;
    assign idx             = avs_address[4:2];
    assign avs_waitrequest = acc & ~s_r.ack;
    assign avs_readdata    = {24'h000000, s_r.rdata};
    assign irq             = s_r.irq;
    assign line_drv        = '{scl_out: 1'b0, scl_oe: s_r.scl_drv, sda_out: 1'b0, sda_oe: s_r.sda_drv};

    always_comb begin
        s_nxt = s_r;
        go_tx = 1'b0;
        go_rx = 1'b0;
        abort = 1'b0;
        s_nxt.scl_m = scl_in;
        s_nxt.scl_s = s_r.scl_m;
        s_nxt.scl_d = s_r.scl_s;
        s_nxt.sda_m = sda_in;
        s_nxt.sda_s = s_r.sda_m;
        s_nxt.sda_d = s_r.sda_s;
        tick     = (s_r.cnt == s_r.div);
        start_ev = s_r.scl_s & s_r.scl_d & s_r.sda_d & ~s_r.sda_s;
        stop_ev  = s_r.scl_s & s_r.scl_d & ~s_r.sda_d & s_r.sda_s;
        stall    = s_r.nack | s_r.bef | (s_r.sst & s_r.sse);
        rx_now   = s_r.rx & ~s_r.addr_ph;
        hi_end   = (s_r.scl_s & tick) | (~s_r.scl_s & (s_r.cnt != 16'h0000));
        if (start_ev) begin
            s_nxt.occ = 1'b1;
        end
        if (stop_ev) begin
            s_nxt.occ = 1'b0;
        end

        // Read data is latched at the first edge; side effects land at the second edge, which ends the transfer.
        s_nxt.ack = acc & ~s_r.ack;
        if (avs_read & ~s_r.ack) begin
            unique case (idx)
                `TWB_IDX_DATA:    s_nxt.rdata = s_r.data;
                `TWB_IDX_STATUS:  s_nxt.rdata = {1'b0, s_r.bef, s_r.bus_error_flag, s_r.nack, s_r.sst, 1'b0,
                                                 s_r.master, s_r.xmit};
                `TWB_IDX_CTLSTAT: s_nxt.rdata = {6'h00, s_r.occ, 1'b0};
                `TWB_IDX_CTL1:    s_nxt.rdata = {s_r.sse, 3'h0, s_r.refuse, s_r.irq_en, s_r.stop_req,
                                                 s_r.start_req};
                `TWB_IDX_OWNADDR: s_nxt.rdata = s_r.own_addr;
                `TWB_IDX_DIV:     s_nxt.rdata = s_r.div[7:0];
                default:          s_nxt.rdata = 8'h00;
            endcase
        end
        if (avs_read & s_r.ack & (idx == `TWB_IDX_DATA) & s_r.master & rx_now) begin
            s_nxt.bef = 1'b0;
        end
        if (avs_write & s_r.ack & avs_byteenable[0]) begin
            unique case (idx)
                `TWB_IDX_DATA: begin
                    s_nxt.data = avs_writedata[7:0];
                    if (s_r.master) begin
                        s_nxt.pend = 1'b1;
                        s_nxt.bef  = 1'b0;
                        if (s_r.addr_ph | s_r.start_req) begin
                            s_nxt.addr_ph = 1'b1;
                            s_nxt.rx      = avs_writedata[0];
                            s_nxt.xmit    = ~avs_writedata[0];
                        end
                    end
                end
                `TWB_IDX_STATUS: begin
                    if (avs_writedata[`TWB_ST_BER]) begin
                        s_nxt.bus_error_flag = 1'b0;
                    end
                    if (avs_writedata[`TWB_ST_NACK]) begin
                        s_nxt.nack = 1'b0;
                    end
                    if (avs_writedata[`TWB_ST_SST]) begin
                        s_nxt.sst = 1'b0;
                    end
                end
                `TWB_IDX_CTLSTAT: begin
                    if (avs_writedata[`TWB_CS_OCC] & ~start_ev) begin
                        s_nxt.occ = 1'b0;
                    end
                end
                `TWB_IDX_CTL1: begin
                    s_nxt.start_req = avs_writedata[`TWB_C1_START];
                    s_nxt.stop_req  = avs_writedata[`TWB_C1_STOP];
                    s_nxt.irq_en    = avs_writedata[`TWB_C1_IRQEN];
                    s_nxt.refuse    = avs_writedata[`TWB_C1_REFUSE];
                    s_nxt.sse       = avs_writedata[`TWB_C1_SSE];
                end
                `TWB_IDX_OWNADDR: s_nxt.own_addr = avs_writedata[7:0];
                `TWB_IDX_DIV: begin
                    s_nxt.div[7:0] = avs_writedata[7:0];
                    if (avs_byteenable[1]) begin
                        s_nxt.div[15:8] = avs_writedata[15:8];
                    end
                end
                default: begin
                end
            endcase
        end

        // Engine updates come after the bus side, so a hardware set beats a software clear.
        s_nxt.cnt = tick ? 16'h0000 : s_r.cnt + 16'h0001;
        unique case (s_r.st)
            S_IDLE: begin
                s_nxt.scl_drv = 1'b0;
                s_nxt.sda_drv = 1'b0;
                s_nxt.cnt     = 16'h0000;
                if (s_r.start_req & ~s_r.occ) begin
                    s_nxt.st = S_SETUP;
                end
            end
            S_RSREL: begin
                s_nxt.sda_drv = 1'b0;
                if (tick) begin
                    s_nxt.scl_drv = 1'b0;
                    s_nxt.st      = S_SETUP;
                end
            end
            S_SETUP: begin
                if (~s_r.scl_s) begin
                    s_nxt.cnt = 16'h0000;
                    if (~s_r.master & ~s_r.scl_drv) begin
                        abort = 1'b1;
                    end
                end else if (tick) begin
                    s_nxt.sda_drv = 1'b1;
                    s_nxt.st      = S_HOLD;
                end
            end
            S_HOLD: begin
                if (tick) begin
                    s_nxt.scl_drv   = 1'b1;
                    s_nxt.start_req = 1'b0;
                    s_nxt.addr_ph   = 1'b1;
                    if (s_r.master & s_r.pend) begin
                        go_tx = 1'b1;
                    end else begin
                        s_nxt.master = 1'b1;
                        s_nxt.bef    = 1'b1;
                        s_nxt.st     = S_STALL;
                    end
                end
            end
            S_STALL: begin
                s_nxt.scl_drv = 1'b1;
                s_nxt.cnt     = 16'h0000;
                if (s_r.stop_req) begin
                    s_nxt.sda_drv = 1'b1;
                    s_nxt.st      = S_STOPA;
                end else if (~stall & s_r.pend & s_r.start_req) begin
                    s_nxt.sda_drv = 1'b0;
                    s_nxt.st      = S_RSREL;
                end else if (~stall & s_r.pend) begin
                    go_tx = 1'b1;
                end else if (~stall & rx_now & ~s_r.start_req) begin
                    go_rx = 1'b1;
                end
            end
            S_LOW: begin
                if (tick) begin
                    s_nxt.scl_drv = 1'b0;
                    s_nxt.st      = S_HIGH;
                end
            end
            S_HIGH: begin
                if (s_r.scl_s & (s_r.cnt == 16'h0000)) begin
                    s_nxt.smp = s_r.sda_s;
                    // The line is open drain, so a released bit may legally read low only while receiving or on the acknowledge bit.
                    if (~rx_now & (s_r.bitn != 4'h8) & ~s_r.sda_drv & ~s_r.sda_s) begin
                        abort = 1'b1;
                    end
                end else if (s_r.scl_s & (s_r.sda_s != s_r.smp)) begin
                    abort = 1'b1;
                end
                if (~s_r.scl_s & (s_r.cnt == 16'h0000)) begin
                    s_nxt.cnt = 16'h0000;
                end else if (hi_end & ~abort) begin
                    s_nxt.scl_drv = 1'b1;
                    s_nxt.cnt     = 16'h0000;
                    s_nxt.st      = S_LOW;
                    s_nxt.bitn    = s_r.bitn + 4'h1;
                    if (s_r.bitn != 4'h8) begin
                        s_nxt.sh = {s_r.sh[6:0], s_r.smp};
                        if (s_r.bitn == 4'h7) begin
                            s_nxt.sda_drv = rx_now & ~s_r.refuse;
                        end else begin
                            s_nxt.sda_drv = ~rx_now & ~s_r.sh[6];
                        end
                    end else begin
                        s_nxt.sda_drv = 1'b0;
                        s_nxt.st      = S_STALL;
                        if (rx_now) begin
                            s_nxt.data = s_r.sh;
                            s_nxt.bef  = 1'b1;
                        end else if (s_r.addr_ph) begin
                            s_nxt.addr_ph = 1'b0;
                            s_nxt.nack    = s_r.smp;
                            if (~s_r.smp & s_r.sse) begin
                                s_nxt.sst = 1'b1;
                            end else if (~s_r.smp & s_r.xmit) begin
                                s_nxt.bef = 1'b1;
                            end else if (~s_r.smp) begin
                                go_rx = 1'b1;
                            end
                        end else begin
                            s_nxt.nack = s_r.smp;
                            s_nxt.bef  = ~s_r.smp;
                        end
                    end
                end
            end
            S_STOPA: begin
                if (tick) begin
                    s_nxt.scl_drv = 1'b0;
                    s_nxt.st      = S_STOPB;
                end
            end
            S_STOPB: begin
                if (~s_r.scl_s) begin
                    s_nxt.cnt = 16'h0000;
                end else if (tick) begin
                    s_nxt.sda_drv = 1'b0;
                    s_nxt.st      = S_STOPC;
                end
            end
            S_STOPC: begin
                if (tick) begin
                    s_nxt.st       = S_IDLE;
                    s_nxt.stop_req = 1'b0;
                    s_nxt.master   = 1'b0;
                    s_nxt.bef      = 1'b0;
                    s_nxt.xmit     = 1'b0;
                    s_nxt.addr_ph  = 1'b0;
                    s_nxt.pend     = 1'b0;
                end
            end
            default: begin
                s_nxt.st = S_IDLE;
            end
        endcase

        if (go_tx) begin
            s_nxt.st      = S_LOW;
            s_nxt.cnt     = 16'h0000;
            s_nxt.bitn    = 4'h0;
            s_nxt.pend    = 1'b0;
            s_nxt.sh      = s_r.data;
            s_nxt.sda_drv = ~s_r.data[7];
        end
        if (go_rx) begin
            s_nxt.st      = S_LOW;
            s_nxt.cnt     = 16'h0000;
            s_nxt.bitn    = 4'h0;
            s_nxt.sh      = 8'h00;
            s_nxt.sda_drv = 1'b0;
        end
        // A lost master only listens afterwards; slave matching lives outside this engine.
        if (abort) begin
            s_nxt.st        = S_IDLE;
            s_nxt.bus_error_flag       = 1'b1;
            s_nxt.master    = 1'b0;
            s_nxt.start_req = 1'b0;
            s_nxt.pend      = 1'b0;
            s_nxt.addr_ph   = 1'b0;
            s_nxt.xmit      = 1'b0;
            s_nxt.scl_drv   = 1'b0;
            s_nxt.sda_drv   = 1'b0;
        end
        s_nxt.irq = s_nxt.irq_en & (s_nxt.bus_error_flag | s_nxt.bef | s_nxt.nack | s_nxt.sst);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r          <= '0;
            s_r.st       <= S_IDLE;
            s_r.div      <= `TWB_DIV_RST;
            s_r.own_addr <= `TWB_OWNADDR_RST;
            s_r.scl_m    <= 1'b1;
            s_r.scl_s    <= 1'b1;
            s_r.scl_d    <= 1'b1;
            s_r.sda_m    <= 1'b1;
            s_r.sda_s    <= 1'b1;
            s_r.sda_d    <= 1'b1;
            s_r.smp      <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

// >>> test/twb_master_chk.sv
/* Port checker of the two-wire bus master engine, bound into the engine.
   Assumes the divider holds 3 while the lines move, so one clock-line phase spans 4 cycles. */
`timescale 1ns/10ps
module twb_master_chk (
    input wire logic                   clk,
    input wire logic                   sys_rst,
    input wire logic                   avs_read,
    input wire logic                   avs_write,
    input wire logic [31:0]            avs_readdata,
    input wire logic                   avs_waitrequest,
    input wire logic                   scl_in,
    input wire twb_pkg::twb_line_drv_s line_drv
);
    import twb_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_wait_once; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_wait_once: assert property (p_wait_once) else $error("wait state longer than one cycle");
    property p_wait_first; $rose(avs_read) || $rose(avs_write) |-> avs_waitrequest; endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait state");
    property p_rd_upper; avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper half not zero");
    property p_pull_only; line_drv.scl_out == 1'b0 && line_drv.sda_out == 1'b0; endproperty
    a_pull_only: assert property (p_pull_only) else $error("line driven high");
    property p_low_phase; $rose(line_drv.scl_oe) |-> line_drv.scl_oe [*4]; endproperty
    a_low_phase: assert property (p_low_phase) else $error("clock low phase too short");
    // A rival pulling the line low may end the high phase early, so those cycles are exempt.
    property p_high_phase; $fell(line_drv.scl_oe) |=> (!line_drv.scl_oe || !$past(scl_in)) [*5]; endproperty
    a_high_phase: assert property (p_high_phase) else $error("clock high phase too short");
    property p_stretch; $fell(line_drv.scl_oe) && !scl_in |=> !line_drv.scl_oe [*2]; endproperty
    a_stretch: assert property (p_stretch) else $error("stretched clock pulled again");
    property p_start_stall;
        $rose(line_drv.sda_oe) && !line_drv.scl_oe && !$past(line_drv.scl_oe)
            |-> ##[1:40] (line_drv.scl_oe || !line_drv.sda_oe);
    endproperty
    a_start_stall: assert property (p_start_stall) else $error("clock not held after start");
    c_stretch: cover property ($fell(line_drv.scl_oe) && !scl_in);
    c_start: cover property ($rose(line_drv.sda_oe) && !line_drv.scl_oe);
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule

// >>> test/twb_slave_model.sv
/* Behavioural slave on the two-wire bus: acknowledges its address, keeps written bytes, sends a counting pattern.
   Assumes open-drain lines with pull-ups; a pull output high holds that line low. */
`timescale 1ns/10ps
module twb_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input  wire logic  scl,
    input  wire logic  sda,
    input  wire logic  stretch,
    output logic       scl_pull,
    output logic       sda_pull,
    output logic [7:0] last_rx,
    output logic       got_nack
);
    logic [3:0] n;
    logic [7:0] sh, tx;
    logic       adr, rd, sel;
    initial begin
        {n, sh, tx, adr, rd, sel, scl_pull, sda_pull, got_nack} = '0;
        last_rx = 8'h00;
    end
    always @(negedge sda) #1 if (scl) begin
        {n, adr, sel, got_nack} = {4'h0, 1'b1, 1'b0, 1'b0};
        tx = 8'h94;
    end
    always @(posedge sda) #1 if (scl) begin
        {adr, sel, sda_pull} = 3'b000;
    end
    always @(posedge scl) begin
        if (n < 8) sh = {sh[6:0], sda};
        else if (rd && sel) begin
            got_nack = sda;
            sel = !sda;
            tx = tx + 8'h11;
        end
        n = n + 4'h1;
    end
    always @(negedge scl) begin
        if (n == 9) {n, adr} = 5'h00;
        if (n == 8 && adr) begin
            sel = (sh[7:1] == ADDR);
            rd = sh[0];
        end
        else if (n == 8 && !rd) last_rx = sh;
        if (n == 8) sda_pull = sel && (!rd || adr);
        else sda_pull = sel && rd && !tx[3'(7 - n)];
        // Holding the ack clock low is what a busy slave does; the master must wait it out.
        if (n == 8 && stretch) begin
            scl_pull = 1'b1;
            #200;
            scl_pull = 1'b0;
        end
    end
endmodule

// >>> test/twb_master_tb_top.sv
/* Self-checking bench of the two-wire bus master engine with one slave model on an open-drain bus.
   Assumes pull-ups on both lines; the bench may pull either line itself to play a rival party. */
`timescale 1ns/10ps
`include "twb_defs.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module twb_master_tb_top;
    import twb_pkg::*;
    localparam logic [6:0] SA = 7'h2a;
    localparam logic [2:0] DAT = `TWB_IDX_DATA, STA = `TWB_IDX_STATUS, CST = `TWB_IDX_CTLSTAT, CT1 = `TWB_IDX_CTL1;
    localparam int BEF = `TWB_ST_BEF, BUS_ERROR_FLAG = `TWB_ST_BER, NAK = `TWB_ST_NACK, SST = `TWB_ST_SST, MAS = `TWB_ST_MASTER;
    logic          clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic          tb_scl = 1'b0, tb_sda = 1'b0, stretch = 1'b0;
    logic [4:0]    avs_address = 5'h00;
    logic [3:0]    avs_byteenable = 4'hf;
    logic [31:0]   avs_writedata = 32'h0, avs_readdata, rd;
    logic          avs_waitrequest, irq, scl_w, sda_w, s_scl, s_sda, s_nack;
    logic [7:0]    s_rx;
    twb_line_drv_s line_drv;
    int            error_cnt = 0, num_checks = 0;
    always #4 clk = ~clk;
    assign scl_w = ~line_drv.scl_oe & ~s_scl & ~tb_scl;
    assign sda_w = ~line_drv.sda_oe & ~s_sda & ~tb_sda;
    twb_master dut_u (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_w), .sda_in(sda_w),
        .line_drv(line_drv), .irq(irq));
    twb_slave_model #(.ADDR(SA)) slv_u (.scl(scl_w), .sda(sda_w), .stretch(stretch), .scl_pull(s_scl),
        .sda_pull(s_sda), .last_rx(s_rx), .got_nack(s_nack));
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [2:0] idx, input logic [31:0] d);
        int k;
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= d;
        if (w) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            error_cnt++;
            report_and_stop();
        end
    endtask
    // Polls one register bit; the bound is far above the longest byte at divider 3.
    task automatic wait_bit(input logic [2:0] idx, input int b, input logic v);
        int k;
        k = 0;
        do begin
            bus(1'b0, idx, 32'h0);
            k++;
        end while (rd[b] !== v && k < 4000);
        if (rd[b] !== v) begin
            error_cnt++;
            report_and_stop();
        end
    endtask
    task automatic get_bus(input logic [7:0] c);
        bus(1'b1, CT1, {24'h0, c | 8'h01});
        wait_bit(STA, MAS, 1'b1);
        bus(1'b0, STA, 32'h0);
        `CHK("start_empty", 1'b1, rd[BEF])
        `CHK("start_irq", c[`TWB_C1_IRQEN], irq)
    endtask
    task automatic put(input logic [7:0] b, input int f);
        bus(1'b1, DAT, {24'h0, b});
        wait_bit(STA, f, 1'b1);
    endtask
    task automatic stop_bus(input logic [7:0] c);
        bus(1'b1, CT1, {24'h0, c | 8'h02});
        wait_bit(CT1, `TWB_C1_STOP, 1'b0);
        bus(1'b0, STA, 32'h0);
        `CHK("stop_master", 1'b0, rd[MAS])
        `CHK("stop_lines", 2'b00, {line_drv.scl_oe, line_drv.sda_oe})
        wait_bit(CST, `TWB_CS_OCC, 1'b0);
    endtask
    task automatic sc_reset;
        bus(1'b0, STA, 32'h0);
        `CHK("status_rst", 32'h0, rd)
        bus(1'b0, `TWB_IDX_DIV, 32'h0);
        `CHK("div_rst", 32'(8'(`TWB_DIV_RST)), rd)
        bus(1'b1, `TWB_IDX_DIV, 32'h3);
        bus(1'b1, 3'h6, 32'hff);
        bus(1'b0, 3'h6, 32'h0);
        `CHK("unmapped", 32'h0, rd)
    endtask
    task automatic sc_write;
        stretch <= 1'b1;
        get_bus(8'h04);
        put({SA, 1'b0}, BEF);
        `CHK("addr_nack", 1'b0, rd[NAK])
        put(8'h3c, BEF);
        `CHK("slave_byte", 8'h3c, s_rx)
        `CHK("empty_irq", 1'b1, irq)
        stop_bus(8'h00);
        stretch <= 1'b0;
    endtask
    task automatic sc_refused;
        get_bus(8'h00);
        put(8'h00, NAK);
        `CHK("nack_empty", 1'b0, rd[BEF])
        `CHK("nack_irq_off", 1'b0, irq)
        `CHK("nack_stall", 1'b1, line_drv.scl_oe)
        stop_bus(8'h00);
        bus(1'b1, STA, 32'h10);
        bus(1'b0, STA, 32'h0);
        `CHK("nack_clear", 1'b0, rd[NAK])
    endtask
    task automatic sc_read;
        get_bus(8'h00);
        put({SA, 1'b1}, BEF);
        `CHK("rx_acked", 1'b0, s_nack)
        bus(1'b1, CT1, 32'h08);
        bus(1'b0, DAT, 32'h0);
        `CHK("rx_first", 32'ha5, rd)
        wait_bit(STA, BEF, 1'b1);
        `CHK("rx_refused", 1'b1, s_nack)
        stop_bus(8'h00);
    endtask
    task automatic sc_stall;
        get_bus(8'h80);
        put({SA, 1'b1}, SST);
        `CHK("sst_no_rx", 1'b0, rd[BEF])
        `CHK("sst_hold", 1'b1, line_drv.scl_oe)
        bus(1'b1, CT1, 32'h81);
        bus(1'b1, DAT, {24'h0, SA, 1'b0});
        bus(1'b1, STA, 32'h08);
        wait_bit(STA, SST, 1'b1);
        stop_bus(8'h80);
        bus(1'b1, STA, 32'h08);
        bus(1'b0, STA, 32'h0);
        `CHK("sst_clear", 1'b0, rd[SST])
    endtask
    task automatic sc_arbit;
        get_bus(8'h00);
        bus(1'b1, DAT, 32'hfe);
        tb_sda <= 1'b1;
        wait_bit(STA, BUS_ERROR_FLAG, 1'b1);
        `CHK("arb_master", 1'b0, rd[MAS])
        `CHK("arb_lines", 2'b00, {line_drv.scl_oe, line_drv.sda_oe})
        tb_sda <= 1'b0;
        bus(1'b1, STA, 32'h20);
        wait_bit(CST, `TWB_CS_OCC, 1'b0);
    endtask
    task automatic sc_busy;
        tb_sda <= 1'b1;
        wait_bit(CST, `TWB_CS_OCC, 1'b1);
        bus(1'b1, CT1, 32'h01);
        repeat (20) bus(1'b0, STA, 32'h0);
        `CHK("busy_wait", 1'b0, rd[MAS])
        tb_sda <= 1'b0;
        wait_bit(STA, MAS, 1'b1);
        stop_bus(8'h00);
        tb_scl <= 1'b1;
        bus(1'b1, CT1, 32'h01);
        wait_bit(STA, BUS_ERROR_FLAG, 1'b1);
        `CHK("err_master", 1'b0, rd[MAS])
        tb_scl <= 1'b0;
        bus(1'b1, STA, 32'h20);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        sc_reset();
        sc_write();
        sc_refused();
        sc_read();
        sc_stall();
        sc_arbit();
        sc_busy();
        report_and_stop();
    end
endmodule
bind twb_master twb_master_chk chk_u (.clk(clk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .line_drv(line_drv));
